// [rtl/odm_decode.sv]
// Purpose: Decode fetched opcode bytes into operation, mode, length, cycles
// Assumes: fetch_byte is the first byte of an instruction or its prefix
// Notes:   One result per opcode; a stack prefix alone gives no result
`timescale 1ns/10ps

module odm_decode (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            fetch_valid,
  input  wire logic [7:0]      fetch_byte,
  input  wire logic            flush,
  output odm_pkg::odm_dec_t    dec_q,
  output logic                 dec_valid_q,
  output logic                 prefix_pending_q
);

  // ----------------------------------------------------------------------
  // Entry builders
  // ----------------------------------------------------------------------
  function automatic odm_pkg::odm_dec_t mk(
    input odm_pkg::odm_op_t   op,
    input odm_pkg::odm_mode_t mode,
    input logic [2:0]         len,
    input logic [3:0]         cyc
  );
    odm_pkg::odm_dec_t d;
    d          = odm_pkg::DEC_RESET;
    d.op       = op;
    d.mode     = mode;
    d.len      = len;
    d.cycles   = cyc;
    d.illegal  = (op == odm_pkg::OP_ILLEGAL);
    return d;
  endfunction : mk

  // Register/memory operation chosen by row
  function automatic odm_pkg::odm_op_t rm_op(input logic [3:0] row);
    odm_pkg::odm_op_t op;
    op = odm_pkg::OP_ILLEGAL;
    case (row)
      odm_pkg::ROW_0: op = odm_pkg::OP_SUBTRACT;
      odm_pkg::ROW_1: op = odm_pkg::OP_COMPARE_ACC;
      odm_pkg::ROW_2: op = odm_pkg::OP_SUBTRACT_BORROW;
      odm_pkg::ROW_3: op = odm_pkg::OP_COMPARE_INDEX;
      odm_pkg::ROW_4: op = odm_pkg::OP_AND;
      default:        op = odm_pkg::OP_ILLEGAL;
    endcase
    return op;
  endfunction : rm_op

  // ----------------------------------------------------------------------
  // Unprefixed opcode
  // ----------------------------------------------------------------------
  function automatic odm_pkg::odm_dec_t dec_plain(input logic [7:0] opc);
    odm_pkg::odm_dec_t d;
    logic [3:0]        col;
    logic [3:0]        row;
    col = opc[7:4];
    row = opc[3:0];
    d   = mk(odm_pkg::OP_ILLEGAL, odm_pkg::MODE_INHERENT,
             odm_pkg::LEN_1, odm_pkg::CYC_1);
    if (row <= odm_pkg::ROW_MAX) begin
      case (col)
        odm_pkg::COL_BIT_BRANCH: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_BRANCH_IF_BIT_SET, odm_pkg::MODE_DIRECT,
                   odm_pkg::LEN_3, odm_pkg::CYC_5);
          else if (row == odm_pkg::ROW_1)
            d = mk(odm_pkg::OP_BRANCH_IF_BIT_CLEAR, odm_pkg::MODE_DIRECT,
                   odm_pkg::LEN_3, odm_pkg::CYC_5);
        end
        odm_pkg::COL_BIT_MANIP: begin
          d = mk(row[0] ? odm_pkg::OP_CLEAR_DIRECT_BIT
                        : odm_pkg::OP_SET_DIRECT_BIT,
                 odm_pkg::MODE_DIRECT, odm_pkg::LEN_2,
                 odm_pkg::CYC_4);
          d.bit_num = row[3:1];
        end
        odm_pkg::COL_REL: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_BRANCH_ALWAYS, odm_pkg::MODE_RELATIVE,
                   odm_pkg::LEN_2, odm_pkg::CYC_3);
          else if (row == odm_pkg::ROW_1)
            d = mk(odm_pkg::OP_BRANCH_NEVER, odm_pkg::MODE_RELATIVE,
                   odm_pkg::LEN_2, odm_pkg::CYC_3);
        end
        odm_pkg::COL_RMW_DIR: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_NEGATE, odm_pkg::MODE_DIRECT,
                   odm_pkg::LEN_2, odm_pkg::CYC_4);
          else if (row == odm_pkg::ROW_1)
            d = mk(odm_pkg::OP_COMPARE_BRANCH_EQUAL, odm_pkg::MODE_DIRECT,
                   odm_pkg::LEN_3, odm_pkg::CYC_5);
          else if (row == odm_pkg::ROW_3)
            d = mk(odm_pkg::OP_COMPLEMENT, odm_pkg::MODE_DIRECT,
                   odm_pkg::LEN_2, odm_pkg::CYC_4);
        end
        odm_pkg::COL_RMW_ACC: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_NEGATE, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_1);
          else if (row == odm_pkg::ROW_1)
            d = mk(odm_pkg::OP_COMPARE_BRANCH_EQUAL,
                   odm_pkg::MODE_IMMEDIATE,
                   odm_pkg::LEN_3, odm_pkg::CYC_4);
        end
        odm_pkg::COL_RMW_IDX: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_NEGATE, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_1);
          else if (row == odm_pkg::ROW_2)
            d = mk(odm_pkg::OP_DIVIDE, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_7);
          else if (row == odm_pkg::ROW_3)
            d = mk(odm_pkg::OP_COMPLEMENT, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_1);
          else if (row == odm_pkg::ROW_4)
            d = mk(odm_pkg::OP_SHIFT_RIGHT, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_1);
        end
        odm_pkg::COL_RMW_BOFS: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_NEGATE, odm_pkg::MODE_INDEXED_BYTE_OFFSET,
                   odm_pkg::LEN_2, odm_pkg::CYC_4);
          else if (row == odm_pkg::ROW_1)
            d = mk(odm_pkg::OP_COMPARE_BRANCH_EQUAL,
                   odm_pkg::MODE_INDEXED_OFFSET_POSTINC,
                   odm_pkg::LEN_3, odm_pkg::CYC_5);
          else if (row == odm_pkg::ROW_2)
            d = mk(odm_pkg::OP_NIBBLE_SWAP, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_3);
          else if (row == odm_pkg::ROW_3)
            d = mk(odm_pkg::OP_COMPLEMENT,
                   odm_pkg::MODE_INDEXED_BYTE_OFFSET,
                   odm_pkg::LEN_2, odm_pkg::CYC_4);
        end
        odm_pkg::COL_RMW_NOFS: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_NEGATE, odm_pkg::MODE_INDEXED_NO_OFFSET,
                   odm_pkg::LEN_1, odm_pkg::CYC_3);
          else if (row == odm_pkg::ROW_2)
            d = mk(odm_pkg::OP_DECIMAL_ADJUST, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_2);
          else if (row == odm_pkg::ROW_3)
            d = mk(odm_pkg::OP_COMPLEMENT, odm_pkg::MODE_INDEXED_NO_OFFSET,
                   odm_pkg::LEN_1, odm_pkg::CYC_3);
        end
        odm_pkg::COL_CTRL: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_RETURN_INTERRUPT, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_7);
          else if (row == odm_pkg::ROW_1)
            d = mk(odm_pkg::OP_RETURN_SUBROUTINE, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_4);
          else if (row == odm_pkg::ROW_3)
            d = mk(odm_pkg::OP_SOFTWARE_INTERRUPT, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_9);
          else if (row == odm_pkg::ROW_4)
            d = mk(odm_pkg::OP_ACC_TO_FLAGS, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_2);
        end
        odm_pkg::COL_CTRL_B: begin
          case (row)
            odm_pkg::ROW_0: d.op = odm_pkg::OP_BRANCH_GE_SIGNED;
            odm_pkg::ROW_1: d.op = odm_pkg::OP_BRANCH_LT_SIGNED;
            odm_pkg::ROW_2: d.op = odm_pkg::OP_BRANCH_GT_SIGNED;
            odm_pkg::ROW_3: d.op = odm_pkg::OP_BRANCH_LE_SIGNED;
            default:        d.op = odm_pkg::OP_INDEX_TO_STACK_PTR;
          endcase
          if (row == odm_pkg::ROW_4)
            d = mk(d.op, odm_pkg::MODE_INHERENT,
                   odm_pkg::LEN_1, odm_pkg::CYC_2);
          else
            d = mk(d.op, odm_pkg::MODE_RELATIVE,
                   odm_pkg::LEN_2, odm_pkg::CYC_3);
        end
        odm_pkg::COL_IMMED:
          d = mk(rm_op(row), odm_pkg::MODE_IMMEDIATE,
                 odm_pkg::LEN_2, odm_pkg::CYC_2);
        odm_pkg::COL_DIR:
          d = mk(rm_op(row), odm_pkg::MODE_DIRECT,
                 odm_pkg::LEN_2, odm_pkg::CYC_3);
        odm_pkg::COL_EXTND:
          d = mk(rm_op(row), odm_pkg::MODE_EXTENDED,
                 odm_pkg::LEN_3, odm_pkg::CYC_4);
        odm_pkg::COL_WORD_OFS:
          d = mk(rm_op(row), odm_pkg::MODE_INDEXED_WORD_OFFSET,
                 odm_pkg::LEN_3, odm_pkg::CYC_4);
        odm_pkg::COL_BYTE_OFS:
          d = mk(rm_op(row), odm_pkg::MODE_INDEXED_BYTE_OFFSET,
                 odm_pkg::LEN_2, odm_pkg::CYC_3);
        odm_pkg::COL_NO_OFS:
          d = mk(rm_op(row), odm_pkg::MODE_INDEXED_NO_OFFSET,
                 odm_pkg::LEN_1, odm_pkg::CYC_2);
        default: d = d;
      endcase
    end
    return d;
  endfunction : dec_plain

  // ----------------------------------------------------------------------
  // Opcode following the stack prefix
  // ----------------------------------------------------------------------
  function automatic odm_pkg::odm_dec_t dec_stack(input logic [7:0] opc);
    odm_pkg::odm_dec_t d;
    logic [3:0]        row;
    row = opc[3:0];
    d   = mk(odm_pkg::OP_ILLEGAL, odm_pkg::MODE_INHERENT,
             odm_pkg::LEN_1, odm_pkg::CYC_1);
    if (row <= odm_pkg::ROW_MAX) begin
      case (opc[7:4])
        odm_pkg::COL_RMW_BOFS: begin
          if (row == odm_pkg::ROW_0)
            d = mk(odm_pkg::OP_NEGATE, odm_pkg::MODE_STACK_BYTE_OFFSET,
                   odm_pkg::LEN_3, odm_pkg::CYC_5);
          else if (row == odm_pkg::ROW_1)
            d = mk(odm_pkg::OP_COMPARE_BRANCH_EQUAL,
                   odm_pkg::MODE_STACK_BYTE_OFFSET,
                   odm_pkg::LEN_4, odm_pkg::CYC_6);
          else if (row == odm_pkg::ROW_4)
            d = mk(odm_pkg::OP_SHIFT_RIGHT,
                   odm_pkg::MODE_STACK_BYTE_OFFSET,
                   odm_pkg::LEN_3, odm_pkg::CYC_5);
        end
        odm_pkg::COL_WORD_OFS:
          d = mk(rm_op(row), odm_pkg::MODE_STACK_WORD_OFFSET,
                 odm_pkg::LEN_4, odm_pkg::CYC_5);
        odm_pkg::COL_BYTE_OFS:
          d = mk(rm_op(row), odm_pkg::MODE_STACK_BYTE_OFFSET,
                 odm_pkg::LEN_3, odm_pkg::CYC_4);
        default: d = d;
      endcase
    end
    d.prefixed = 1'b1;
    return d;
  endfunction : dec_stack

  // ----------------------------------------------------------------------
  // Prefix tracking and result register
  // ----------------------------------------------------------------------
  logic               is_prefix;
  odm_pkg::odm_dec_t  dec_d;

  assign is_prefix = fetch_valid && !prefix_pending_q &&
                     (fetch_byte == odm_pkg::PREFIX_STACK);

  always_comb begin
    if (prefix_pending_q)
      dec_d = dec_stack(fetch_byte);
    else
      dec_d = dec_plain(fetch_byte);
  end

  // A flush drops a half-taken prefix so a redirected stream starts clean
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prefix_pending_q <= 1'b0;
    end else if (flush) begin
      prefix_pending_q <= 1'b0;
    end else if (fetch_valid) begin
      prefix_pending_q <= is_prefix;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_valid_q <= 1'b0;
    end else begin
      dec_valid_q <= fetch_valid && !flush && !is_prefix;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_q <= odm_pkg::DEC_RESET;
    end else if (fetch_valid && !flush && !is_prefix) begin
      dec_q <= dec_d;
    end
  end

endmodule : odm_decode

// [rtl/odm_pkg.sv]
// Purpose: Shared types and constants for the opcode decode map block
// Assumes: One fetched byte per accepted cycle, low opcode nibbles 0 to 4
// Notes:   Lengths include the stack prefix byte where one is present
//
// Contract
// - 0x00/0x01 test direct bit 0, branch if set/clear; 3 bytes, 5 cycles
// - High nibble 1: even sets, odd clears direct bit lo/2; 2 bytes, 4 cycles
// - 0x20 branch always, 0x21 branch never; 2 bytes, 3 cycles
// - 0x90..0x93 signed branches ge, lt, gt, le; 2 bytes, 3 cycles
// - 0x84 accumulator to flags, 0x94 index to stack pointer; 1 byte, 2
// - Column A immediate 2/2, B direct 2/3, C extended 3/4
// - Column D word-indexed 3/4; prefixed D stack word offset 4/5
// - Column E byte-indexed 2/3, prefixed E stack 3/4, F indexed 1/2
// - Low nibble selects subtract, compare, subtract borrow, compare index, AND
// - Negate forms 30,40,50,60,9E60,70 with their lengths and cycles
// - Complement 33,53,63,73; shift right 54 and stack form 9E64
// - Compare-branch-equal 31 direct, 41 immediate, 61 post-increment, 9E61 stack form
// - Byte 0x9E prefixes 60, 61, 64 and high nibble D or E into stack form
// - High nibble picks column, low nibble row; length, cycles, mode follow
package odm_pkg;

  localparam logic [7:0] PREFIX_STACK  = 8'h9E;
  localparam int         OPCODE_W      = 8;

  // Table coordinates
  localparam logic [3:0] COL_BIT_BRANCH = 4'h0;
  localparam logic [3:0] COL_BIT_MANIP  = 4'h1;
  localparam logic [3:0] COL_REL        = 4'h2;
  localparam logic [3:0] COL_RMW_DIR    = 4'h3;
  localparam logic [3:0] COL_RMW_ACC    = 4'h4;
  localparam logic [3:0] COL_RMW_IDX    = 4'h5;
  localparam logic [3:0] COL_RMW_BOFS   = 4'h6;
  localparam logic [3:0] COL_RMW_NOFS   = 4'h7;
  localparam logic [3:0] COL_CTRL       = 4'h8;
  localparam logic [3:0] COL_CTRL_B     = 4'h9;
  localparam logic [3:0] COL_IMMED      = 4'hA;
  localparam logic [3:0] COL_DIR        = 4'hB;
  localparam logic [3:0] COL_EXTND      = 4'hC;
  localparam logic [3:0] COL_WORD_OFS   = 4'hD;
  localparam logic [3:0] COL_BYTE_OFS   = 4'hE;
  localparam logic [3:0] COL_NO_OFS     = 4'hF;
  localparam logic [3:0] ROW_MAX        = 4'h4;

  // Row codes with fixed meaning
  localparam logic [3:0] ROW_0 = 4'h0;
  localparam logic [3:0] ROW_1 = 4'h1;
  localparam logic [3:0] ROW_2 = 4'h2;
  localparam logic [3:0] ROW_3 = 4'h3;
  localparam logic [3:0] ROW_4 = 4'h4;

  // Instruction lengths in bytes
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;

  // Execution cycle counts
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_5 = 4'h5;
  localparam logic [3:0] CYC_6 = 4'h6;
  localparam logic [3:0] CYC_7 = 4'h7;
  localparam logic [3:0] CYC_9 = 4'h9;

  typedef enum logic [4:0] {
    OP_ILLEGAL,
    OP_BRANCH_IF_BIT_SET,
    OP_BRANCH_IF_BIT_CLEAR,
    OP_SET_DIRECT_BIT,
    OP_CLEAR_DIRECT_BIT,
    OP_BRANCH_ALWAYS,
    OP_BRANCH_NEVER,
    OP_BRANCH_GE_SIGNED,
    OP_BRANCH_LT_SIGNED,
    OP_BRANCH_GT_SIGNED,
    OP_BRANCH_LE_SIGNED,
    OP_ACC_TO_FLAGS,
    OP_INDEX_TO_STACK_PTR,
    OP_SUBTRACT,
    OP_COMPARE_ACC,
    OP_SUBTRACT_BORROW,
    OP_COMPARE_INDEX,
    OP_AND,
    OP_NEGATE,
    OP_COMPLEMENT,
    OP_SHIFT_RIGHT,
    OP_COMPARE_BRANCH_EQUAL,
    OP_RETURN_INTERRUPT,
    OP_RETURN_SUBROUTINE,
    OP_SOFTWARE_INTERRUPT,
    OP_DIVIDE,
    OP_NIBBLE_SWAP,
    OP_DECIMAL_ADJUST
  } odm_op_t;

  typedef enum logic [3:0] {
    MODE_INHERENT,
    MODE_IMMEDIATE,
    MODE_DIRECT,
    MODE_EXTENDED,
    MODE_RELATIVE,
    MODE_INDEXED_NO_OFFSET,
    MODE_INDEXED_BYTE_OFFSET,
    MODE_INDEXED_WORD_OFFSET,
    MODE_INDEXED_OFFSET_POSTINC,
    MODE_STACK_BYTE_OFFSET,
    MODE_STACK_WORD_OFFSET
  } odm_mode_t;

  typedef struct packed {
    odm_op_t    op;
    odm_mode_t  mode;
    logic [2:0] bit_num;
    logic [2:0] len;
    logic [3:0] cycles;
    logic       prefixed;
    logic       illegal;
  } odm_dec_t;

  localparam odm_dec_t DEC_RESET = '{
    op: OP_ILLEGAL, mode: MODE_INHERENT, bit_num: 3'h0, len: 3'h0,
    cycles: 4'h0, prefixed: 1'b0, illegal: 1'b0};

endpackage : odm_pkg

// [test/odm_decode_assertions.sv]
// Purpose: Port-level timing and field checks on the opcode decoder
// Assumes: One fetch byte per cycle, result one cycle after it is taken
// Notes:   Bound into every odm_decode instance
`timescale 1ns/10ps

module odm_decode_assertions (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              fetch_valid,
  input wire logic [7:0]        fetch_byte,
  input wire logic              flush,
  input wire odm_pkg::odm_dec_t dec_q,
  input wire logic              dec_valid_q,
  input wire logic              prefix_pending_q
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic       pre_take;
  logic       take;
  logic [2:0] half_row;
  assign pre_take = fetch_valid && !flush && !prefix_pending_q
                    && (fetch_byte == odm_pkg::PREFIX_STACK);
  assign take     = fetch_valid && !flush && !pre_take;
  assign half_row = fetch_byte[3:1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ANSWER: assert property (take |=> dec_valid_q)
    else $error("taken opcode gave no result");
  AST_NO_ANSWER: assert property (!take |=> !dec_valid_q)
    else $error("result without a taken opcode");
  AST_PREFIX_WAIT: assert property (
    pre_take |=> prefix_pending_q && !dec_valid_q)
    else $error("prefix byte not held pending");
  AST_FLUSH: assert property (
    flush |=> !prefix_pending_q && !dec_valid_q)
    else $error("flush did not drop the cycle");
  AST_PREFIX_MARK: assert property (
    take |=> dec_q.prefixed == $past(prefix_pending_q))
    else $error("prefixed mark wrong");
  AST_HOLD: assert property (!dec_valid_q |-> $stable(dec_q))
    else $error("result changed without a new opcode");
  AST_ILLEGAL: assert property (
    dec_valid_q |-> dec_q.illegal == (dec_q.op == odm_pkg::OP_ILLEGAL))
    else $error("illegal result carries an operation");
  AST_ROW_ILLEGAL: assert property (
    take && fetch_byte[3:0] > odm_pkg::ROW_MAX |=> dec_q.illegal)
    else $error("unlisted row not flagged");
  AST_SUB_IMM: assert property (
    take && !prefix_pending_q && fetch_byte == 8'hA0
    |=> dec_q.op == odm_pkg::OP_SUBTRACT && dec_q.len == 3'h2
        && dec_q.cycles == 4'h2)
    else $error("immediate subtract decoded wrong");
  AST_STACK_WORD: assert property (
    take && prefix_pending_q && fetch_byte[7:4] == 4'hD
    && fetch_byte[3:0] <= odm_pkg::ROW_MAX
    |=> dec_q.mode == odm_pkg::MODE_STACK_WORD_OFFSET
        && dec_q.len == 3'h4 && dec_q.cycles == 4'h5)
    else $error("stack word form decoded wrong");
  AST_BIT_NUM: assert property (
    take && !prefix_pending_q && fetch_byte[7:4] == 4'h1
    && fetch_byte[3:0] <= odm_pkg::ROW_MAX
    |=> dec_q.bit_num == $past(half_row) && dec_q.len == 3'h2)
    else $error("direct bit number wrong");
endmodule : odm_decode_assertions

bind odm_decode odm_decode_assertions u_chk (
  .clk(clk), .rst_b(rst_b), .fetch_valid(fetch_valid),
  .fetch_byte(fetch_byte), .flush(flush), .dec_q(dec_q),
  .dec_valid_q(dec_valid_q), .prefix_pending_q(prefix_pending_q));

// [test/odm_fetch_model.sv]
// Purpose: Program memory fetch path feeding one byte per request
// Assumes: Requests are made from the bench just after a rising edge
// Notes:   Idle bytes toggle so a stale value is never mistaken for data
`timescale 1ns/10ps

module odm_fetch_model (
  input wire logic  clk,
  output logic       fetch_valid,
  output logic [7:0] fetch_byte
);
  logic       pend;
  logic [7:0] pb;

  initial begin
    fetch_valid = 1'b0;
    fetch_byte  = 8'hA5;
    pend        = 1'b0;
    pb          = 8'h00;
  end

  // Drive on the falling edge, away from the decoder's sampling edge
  always @(negedge clk) begin
    if (pend) begin
      fetch_valid <= 1'b1;
      fetch_byte  <= pb;
      pend = 1'b0;
    end else begin
      fetch_valid <= 1'b0;
      fetch_byte  <= ~fetch_byte;
    end
  end

  task automatic put(input logic [7:0] b);
    @(posedge clk);
    pb   = b;
    pend = 1'b1;
  endtask : put
endmodule : odm_fetch_model

// [test/opcode_decode_map_bench.sv]
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Expected decodes written out from the opcode table
// Notes:   Results sampled 1 ns after the edge that loads them
`timescale 1ns/10ps

module opcode_decode_map_bench;
  logic              clk;
  logic              rst_b;
  logic              flush;
  logic              fetch_valid;
  logic [7:0]        fetch_byte;
  odm_pkg::odm_dec_t dec_q;
  logic              dec_valid_q;
  logic              prefix_pending_q;
  int                fails = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  odm_fetch_model u_fm (.clk(clk), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte));
  odm_decode DUT (.clk(clk), .rst_b(rst_b), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .flush(flush), .dec_q(dec_q),
    .dec_valid_q(dec_valid_q), .prefix_pending_q(prefix_pending_q));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      print_verdict();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Byte b0 of 0x9E sends a prefix first; any other b0 is not sent
  task automatic chk(input logic [7:0] b0, input logic [7:0] b1,
    input odm_pkg::odm_op_t op, input odm_pkg::odm_mode_t md,
    input logic [2:0] bn, input logic [2:0] ln, input logic [3:0] cy);
    odm_pkg::odm_dec_t e;
    e = '{op: op, mode: md, bit_num: bn, len: ln, cycles: cy,
      prefixed: (b0 == odm_pkg::PREFIX_STACK), illegal: 1'b0};
    if (b0 == odm_pkg::PREFIX_STACK) u_fm.put(b0);
    u_fm.put(b1);
    @(posedge clk);
    #1;
    cmp(32'(dec_valid_q), 32'h1);
    cmp(32'(dec_q), 32'(e));
  endtask : chk

  task automatic ill(input logic [7:0] b0, input logic [7:0] b1);
    if (b0 == odm_pkg::PREFIX_STACK) u_fm.put(b0);
    u_fm.put(b1);
    @(posedge clk);
    #1;
    cmp(32'(dec_valid_q), 32'h1);
    cmp(32'(dec_q.illegal), 32'h1);
    cmp(32'(dec_q.op), 32'(odm_pkg::OP_ILLEGAL));
    cmp(32'(dec_q.prefixed), 32'(b0 == odm_pkg::PREFIX_STACK));
  endtask : ill

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    cmp(32'(dec_q), 32'(odm_pkg::DEC_RESET));
    cmp(32'(dec_valid_q), 32'h0);
    cmp(32'(prefix_pending_q), 32'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_rows();
    chk(8'h00, 8'h00, odm_pkg::OP_BRANCH_IF_BIT_SET, odm_pkg::MODE_DIRECT, 3'h0, 3'h3, 4'h5);
    chk(8'h00, 8'h01, odm_pkg::OP_BRANCH_IF_BIT_CLEAR, odm_pkg::MODE_DIRECT, 3'h0, 3'h3, 4'h5);
    chk(8'h00, 8'h13, odm_pkg::OP_CLEAR_DIRECT_BIT, odm_pkg::MODE_DIRECT, 3'h1, 3'h2, 4'h4);
    chk(8'h00, 8'h14, odm_pkg::OP_SET_DIRECT_BIT, odm_pkg::MODE_DIRECT, 3'h2, 3'h2, 4'h4);
    chk(8'h00, 8'h20, odm_pkg::OP_BRANCH_ALWAYS, odm_pkg::MODE_RELATIVE, 3'h0, 3'h2, 4'h3);
    chk(8'h00, 8'h21, odm_pkg::OP_BRANCH_NEVER, odm_pkg::MODE_RELATIVE, 3'h0, 3'h2, 4'h3);
    for (int i = 0; i < 4; i++) begin
      chk(8'h00, 8'h90 + 8'(i), odm_pkg::odm_op_t'(odm_pkg::OP_BRANCH_GE_SIGNED + i), odm_pkg::MODE_RELATIVE, 3'h0, 3'h2, 4'h3);
    end
    chk(8'h00, 8'h84, odm_pkg::OP_ACC_TO_FLAGS, odm_pkg::MODE_INHERENT, 3'h0, 3'h1, 4'h2);
    chk(8'h00, 8'h94, odm_pkg::OP_INDEX_TO_STACK_PTR, odm_pkg::MODE_INHERENT, 3'h0, 3'h1, 4'h2);
    chk(8'h00, 8'h52, odm_pkg::OP_DIVIDE,
        odm_pkg::MODE_INHERENT, 3'h0, 3'h1, 4'h7);
    chk(8'h00, 8'h83, odm_pkg::OP_SOFTWARE_INTERRUPT,
        odm_pkg::MODE_INHERENT, 3'h0, 3'h1, 4'h9);
    $display("test rows done");
  endtask : test_rows

  // Every register/memory column against every listed row
  task automatic test_regmem();
    logic [7:0]         col [8] = '{8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'hD0, 8'hE0, 8'hE0, 8'hF0};
    logic [7:0]         pre [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h9E, 8'h00, 8'h9E, 8'h00};
    logic [2:0]         ln [8] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h2, 3'h3, 3'h1};
    logic [3:0]         cy [8] = '{4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h3, 4'h4, 4'h2};
    odm_pkg::odm_mode_t md [8] = '{odm_pkg::MODE_IMMEDIATE, odm_pkg::MODE_DIRECT, odm_pkg::MODE_EXTENDED, odm_pkg::MODE_INDEXED_WORD_OFFSET, odm_pkg::MODE_STACK_WORD_OFFSET, odm_pkg::MODE_INDEXED_BYTE_OFFSET, odm_pkg::MODE_STACK_BYTE_OFFSET, odm_pkg::MODE_INDEXED_NO_OFFSET};
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 5; r++) begin
        chk(pre[c], col[c] + 8'(r), odm_pkg::odm_op_t'(odm_pkg::OP_SUBTRACT + r), md[c], 3'h0, ln[c], cy[c]);
      end
    end
    $display("test regmem done");
  endtask : test_regmem

  task automatic test_rmw();
    chk(8'h00, 8'h30, odm_pkg::OP_NEGATE, odm_pkg::MODE_DIRECT, 3'h0, 3'h2, 4'h4);
    chk(8'h00, 8'h40, odm_pkg::OP_NEGATE, odm_pkg::MODE_INHERENT, 3'h0, 3'h1, 4'h1);
    chk(8'h00, 8'h50, odm_pkg::OP_NEGATE, odm_pkg::MODE_INHERENT, 3'h0, 3'h1, 4'h1);
    chk(8'h00, 8'h60, odm_pkg::OP_NEGATE, odm_pkg::MODE_INDEXED_BYTE_OFFSET, 3'h0, 3'h2, 4'h4);
    chk(8'h9E, 8'h60, odm_pkg::OP_NEGATE, odm_pkg::MODE_STACK_BYTE_OFFSET, 3'h0, 3'h3, 4'h5);
    chk(8'h00, 8'h70, odm_pkg::OP_NEGATE, odm_pkg::MODE_INDEXED_NO_OFFSET, 3'h0, 3'h1, 4'h3);
    chk(8'h00, 8'h33, odm_pkg::OP_COMPLEMENT, odm_pkg::MODE_DIRECT, 3'h0, 3'h2, 4'h4);
    chk(8'h00, 8'h53, odm_pkg::OP_COMPLEMENT, odm_pkg::MODE_INHERENT, 3'h0, 3'h1, 4'h1);
    chk(8'h00, 8'h63, odm_pkg::OP_COMPLEMENT, odm_pkg::MODE_INDEXED_BYTE_OFFSET, 3'h0, 3'h2, 4'h4);
    chk(8'h00, 8'h73, odm_pkg::OP_COMPLEMENT, odm_pkg::MODE_INDEXED_NO_OFFSET, 3'h0, 3'h1, 4'h3);
    chk(8'h00, 8'h54, odm_pkg::OP_SHIFT_RIGHT, odm_pkg::MODE_INHERENT, 3'h0, 3'h1, 4'h1);
    chk(8'h9E, 8'h64, odm_pkg::OP_SHIFT_RIGHT, odm_pkg::MODE_STACK_BYTE_OFFSET, 3'h0, 3'h3, 4'h5);
    chk(8'h00, 8'h31, odm_pkg::OP_COMPARE_BRANCH_EQUAL, odm_pkg::MODE_DIRECT, 3'h0, 3'h3, 4'h5);
    chk(8'h00, 8'h41, odm_pkg::OP_COMPARE_BRANCH_EQUAL, odm_pkg::MODE_IMMEDIATE, 3'h0, 3'h3, 4'h4);
    chk(8'h00, 8'h61, odm_pkg::OP_COMPARE_BRANCH_EQUAL, odm_pkg::MODE_INDEXED_OFFSET_POSTINC, 3'h0, 3'h3, 4'h5);
    chk(8'h9E, 8'h61, odm_pkg::OP_COMPARE_BRANCH_EQUAL, odm_pkg::MODE_STACK_BYTE_OFFSET, 3'h0, 3'h4, 4'h6);
    $display("test rmw done");
  endtask : test_rmw

  task automatic test_illegal();
    ill(8'h00, 8'h05);
    ill(8'h9E, 8'h9E);
    ill(8'h9E, 8'hA0);
    ill(8'h9E, 8'h63);
    ill(8'h9E, 8'h30);
    $display("test illegal done");
  endtask : test_illegal

  task automatic test_back_to_back();
    u_fm.put(8'hA0);
    u_fm.put(8'hB1);
    #1;
    cmp(32'(dec_q.op), 32'(odm_pkg::OP_SUBTRACT));
    @(posedge clk);
    #1;
    cmp(32'(dec_valid_q), 32'h1);
    cmp(32'(dec_q.op), 32'(odm_pkg::OP_COMPARE_ACC));
    @(posedge clk);
    #1;
    cmp(32'(dec_valid_q), 32'h0);
    $display("test back to back done");
  endtask : test_back_to_back

  // Flush lands on the opcode after a prefix: both must be dropped
  task automatic test_flush();
    u_fm.put(8'h9E);
    u_fm.put(8'hA0);
    #1;
    cmp(32'(prefix_pending_q), 32'h1);
    @(negedge clk);
    flush = 1'b1;
    @(posedge clk);
    #1;
    cmp(32'(dec_valid_q), 32'h0);
    cmp(32'(prefix_pending_q), 32'h0);
    @(negedge clk);
    flush = 1'b0;
    chk(8'h00, 8'hB0, odm_pkg::OP_SUBTRACT, odm_pkg::MODE_DIRECT, 3'h0, 3'h2, 4'h3);
    $display("test flush done");
  endtask : test_flush

  task automatic test_mid_reset();
    u_fm.put(8'h9E);
    @(posedge clk);
    #1;
    cmp(32'(prefix_pending_q), 32'h1);
    @(negedge clk);
    rst_b = 1'b0;
    #1;
    test_reset();
    @(negedge clk);
    rst_b = 1'b1;
    chk(8'h00, 8'hC4, odm_pkg::OP_AND, odm_pkg::MODE_EXTENDED, 3'h0, 3'h3, 4'h4);
    $display("test mid reset done");
  endtask : test_mid_reset

  initial begin
    rst_b = 1'b0;
    flush = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    test_reset();
    rst_b = 1'b1;
    test_rows();
    test_regmem();
    test_rmw();
    test_illegal();
    test_back_to_back();
    test_flush();
    test_mid_reset();
    print_verdict();
  end
endmodule : opcode_decode_map_bench
